// File: bdma_pkg.sv
// package for the banked data memory addressing block
package bdma_pkg;
   localparam int          ADDR_W         = 12;       // full data address width
   localparam int          BANK_W         = 4;        // bank index width
   localparam int          LOW_W          = 8;        // in-bank offset width
   localparam int          MEM_BYTES      = 4096;     // full data space
   localparam int          BANK_BYTES     = 256;      // bytes per bank
   localparam logic [3:0]  IMPL_BANKS     = 4'hF;     // banks 0..E hold storage
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;    // access low part below, sfr above
   localparam logic [3:0]  SFR_BANK       = 4'hF;     // bank holding special function regs
   localparam logic [7:0]  PC_LOW_ADDR    = 8'hF9;    // program counter low byte
   localparam logic [7:0]  BANK_SEL_ADDR  = 8'hE0;    // bank select in sfr bank
   localparam logic [7:0]  BANK_SEL_RST   = 8'h00;    // bank select after reset
   localparam logic [7:0]  PC_RST         = 8'h00;    // program counter low after reset
   localparam logic [11:0] APB_BANK_SEL   = 12'h000;  // apb: bank select
   localparam logic [11:0] APB_CMD        = 12'h004;  // apb: command word
   localparam logic [11:0] APB_STATUS     = 12'h008;  // apb: result and flags
   localparam logic [11:0] APB_PC         = 12'h00C;  // apb: program counter low

   // operation codes carried in the command word
   typedef enum logic [1:0] {
      BDMA_OP_READ,       // banked or access read
      BDMA_OP_WRITE,      // banked or access write
      BDMA_OP_LOADBANK,   // load_bank_literal_op
      BDMA_OP_MOVE        // full_address_move_op
   } bdma_op_e;

   // apb request as one carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } bdma_apb_req_s;

   // all state of the block except the storage array
   typedef struct packed {
      logic [3:0]  bank_sel;    // implemented bits of bank_select_reg
      logic [7:0]  pc_low;      // program counter low byte
      logic [7:0]  result;      // last read or moved byte
      logic        zero_flag;   // status zero flag
      logic        busy;        // always cleared; a move completes in one cycle
      logic [11:0] mv_dst;      // move destination
      logic [31:0] prdata;      // registered read data
      logic        pready;      // access answer
   } bdma_state_s;
endpackage : bdma_pkg

// File: bdma_core.sv
// banked data memory addressing with apb command port
// Overview of operation
// RQ1: every byte reached by 12-bit address
// RQ2: sixteen 256-byte banks, bank is upper bits
// RQ3: unimplemented locations read as zero
// RQ4: access window ignores bank select
// RQ5: banked address is bank plus operand
// RQ6: only low four bank bits exist
// RQ7: load bank literal writes bank select
// RQ8: unimplemented bank drops writes, reads zero
// RQ9: status flag updates regardless of bank
// RQ10: move uses full addresses, ignores bank
// RQ11: other ops use bank or access window
// RQ12: F9h in bank 0Fh is program counter
// RQ13: all banks reachable by banked and move modes; the access window reaches only banks 0 and 0Fh
// RQ14: access bit picks window or bank
module bdma_core (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [3:0]  bank_sel_out,
   output logic      [7:0]  pc_low_out
);
   // command word: [1:0] op, [2] access bit, [10:3] operand or literal,
   // [22:11] move source, [31:24] write data; move dest bank rides in [31:28],
   // free to overlap because a move carries no write data of its own
   bdma_pkg::bdma_state_s   st_r;          // registered state
   bdma_pkg::bdma_state_s   st_nxt;        // next state
   bdma_pkg::bdma_apb_req_s req;           // bundled request
   logic [7:0]              mem [0:3839];  // storage of banks 0..E
   logic [11:0]             eff_addr;      // resolved address
   logic [7:0]              rd_byte;       // byte read at eff_addr
   logic                    wr_en;         // storage write strobe
   logic [11:0]             wr_addr;       // storage write address
   logic [7:0]              wr_data;       // storage write data
   logic                    acc_wr;        // apb write access phase
   logic                    acc_rd;        // apb read access phase
   bdma_pkg::bdma_op_e      op;            // decoded operation
   logic                    access_bit;    // window select
   logic [7:0]              operand;       // low address or literal

   assign req          = '{psel, penable, pwrite, paddr, pwdata};
   assign acc_wr       = req.psel & req.penable & req.pwrite & ~st_r.pready;
   assign acc_rd       = req.psel & req.penable & ~req.pwrite & ~st_r.pready;
   assign op           = bdma_pkg::bdma_op_e'(req.pwdata[1:0]);
   assign access_bit   = req.pwdata[2];
   assign operand      = req.pwdata[10:3];

   // the split keeps the hottest general bytes and the sfr bytes from 60h up one access away
   // address resolution: window splits at ACCESS_SPLIT between bank 0 and sfr bank
   always_comb begin
      if (access_bit) begin                                            // [RQ4] [RQ14]
         eff_addr = (operand < bdma_pkg::ACCESS_SPLIT) ? {4'h0, operand}
                                                      : {bdma_pkg::SFR_BANK, operand};
      end else begin
         eff_addr = {st_r.bank_sel, operand};                          // [RQ5] [RQ11] [RQ2]
      end
   end

   // one decode serves the operand path and the move source path, so the two
   // can never disagree about what a dead sfr byte returns
   // reading any 12-bit address; sfr bank decodes bank select and pc, rest zero
   function automatic logic [7:0] rd_at(input logic [11:0] a,
                                        input logic [3:0]  bs,
                                        input logic [7:0]  pc);
      logic [7:0] v;
      v = 8'h00;                                                       // [RQ3]
      if (a[11:8] == bdma_pkg::SFR_BANK) begin
         if (a[7:0] == bdma_pkg::BANK_SEL_ADDR) v = {4'h0, bs};        // [RQ6]
         else if (a[7:0] == bdma_pkg::PC_LOW_ADDR) v = pc;             // [RQ12]
      end
      return v;
   endfunction : rd_at

   // storage bytes read only when the bank is implemented
   always_comb begin
      if (eff_addr[11:8] < bdma_pkg::IMPL_BANKS) rd_byte = mem[eff_addr];  // [RQ1] [RQ13]
      else rd_byte = rd_at(eff_addr, st_r.bank_sel, st_r.pc_low);      // [RQ8] [RQ3]
   end

   // next state and storage write strobe
   always_comb begin
      logic [11:0] src;
      logic [7:0]  mv_byte;
      logic [11:0] tgt;
      logic [7:0]  tdata;
      logic        tgo;
      src     = req.pwdata[22:11];
      mv_byte = (src[11:8] < bdma_pkg::IMPL_BANKS) ? mem[src]
                                                 : rd_at(src, st_r.bank_sel, st_r.pc_low);
      tgt     = eff_addr;
      tdata   = req.pwdata[31:24];
      tgo     = 1'b0;
      st_nxt  = st_r;
      // pready rises one edge into the access phase and drops at the next
      st_nxt.pready = req.psel & req.penable & ~st_r.pready;
      if (acc_rd) begin
         case (req.paddr)
            bdma_pkg::APB_BANK_SEL: st_nxt.prdata = {28'h0, st_r.bank_sel};  // [RQ6]
            bdma_pkg::APB_STATUS:   st_nxt.prdata = {23'h0, st_r.zero_flag, st_r.result};
            bdma_pkg::APB_PC:       st_nxt.prdata = {24'h0, st_r.pc_low};
            default:                st_nxt.prdata = 32'h0;
         endcase
      end
      if (acc_wr) begin
         case (req.paddr)
            bdma_pkg::APB_BANK_SEL: st_nxt.bank_sel = req.pwdata[3:0];  // [RQ6]
            bdma_pkg::APB_CMD: begin
               case (op)
                  bdma_pkg::BDMA_OP_READ: begin
                     st_nxt.result    = rd_byte;
                     st_nxt.zero_flag = (rd_byte == 8'h00);             // [RQ9]
                  end
                  bdma_pkg::BDMA_OP_WRITE: begin
                     tgo              = 1'b1;
                     st_nxt.zero_flag = (tdata == 8'h00);              // [RQ9]
                  end
                  bdma_pkg::BDMA_OP_LOADBANK: begin
                     st_nxt.bank_sel = operand[3:0];                   // [RQ7] [RQ6]
                  end
                  bdma_pkg::BDMA_OP_MOVE: begin
                     // destination packed in high bits of wdata via operand and bits 31:28
                     tgt           = {req.pwdata[31:28], operand};      // [RQ10]
                     tdata         = mv_byte;
                     tgo           = 1'b1;
                     st_nxt.result = mv_byte;
                  end
                  default: tgo = 1'b0;
               endcase
            end
            default: tgo = 1'b0;
         endcase
      end
      st_nxt.busy   = 1'b0;
      st_nxt.mv_dst = tgt;
      wr_en   = 1'b0;
      wr_addr = tgt;
      wr_data = tdata;
      // sfr bank: only pc and bank select are live, the rest swallow writes
      if (tgo) begin
         if (tgt[11:8] < bdma_pkg::IMPL_BANKS) wr_en = 1'b1;           // [RQ8]
         else if (tgt == {bdma_pkg::SFR_BANK, bdma_pkg::PC_LOW_ADDR})
            st_nxt.pc_low = tdata;                                     // [RQ12]
         else if (tgt == {bdma_pkg::SFR_BANK, bdma_pkg::BANK_SEL_ADDR})
            st_nxt.bank_sel = tdata[3:0];                              // [RQ6]
      end
   end

   // a write lands at the first access edge, the same edge at which pready rises; the
   // master holds every qualifier until it sees pready, so the commit is never early
   // storage array has no reset; contents are undefined until written
   always_ff @(posedge ref_clk) begin
      if (wr_en) mem[wr_addr] <= wr_data;                              // [RQ13]
   end

   // one register for all state but the storage array keeps every reset value in a single place
   // single state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{bank_sel: 4'h0, pc_low: bdma_pkg::PC_RST, result: 8'h00,
                   zero_flag: 1'b0, busy: 1'b0, mv_dst: 12'h000,
                   prdata: 32'h0, pready: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata       = st_r.prdata;
   assign pready       = st_r.pready;
   assign pslverr      = 1'b0;
   assign bank_sel_out = st_r.bank_sel;
   assign pc_low_out   = st_r.pc_low;

   // bank select upper bits never read back as one
   property p_bank_hi_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_r.pready && !req.pwrite && req.paddr == bdma_pkg::APB_BANK_SEL) |-> prdata[31:4] == 28'h0;
   endproperty
   a_bank_hi_zero: assert property (p_bank_hi_zero) else $error("bank high bits set"); // [RQ6]

   // load bank literal lands one cycle later
   property p_loadbank;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_LOADBANK)
         |=> bank_sel_out == $past(operand[3:0]);
   endproperty
   a_loadbank: assert property (p_loadbank) else $error("bank literal not loaded"); // [RQ7]

   // banked address uses bank select
   property p_banked;
      @(posedge ref_clk) disable iff (!rst_n)
      !access_bit |-> eff_addr == {st_r.bank_sel, operand};
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong"); // [RQ5]

   // access window never uses bank select
   property p_window;
      @(posedge ref_clk) disable iff (!rst_n)
      access_bit |-> (eff_addr[11:8] == 4'h0 || eff_addr[11:8] == bdma_pkg::SFR_BANK);
   endproperty
   a_window: assert property (p_window) else $error("window bank wrong"); // [RQ4]

   // no storage write into unimplemented bank
   property p_no_wr_hi;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_en |-> wr_addr[11:8] < bdma_pkg::IMPL_BANKS;
   endproperty
   a_no_wr_hi: assert property (p_no_wr_hi) else $error("write to missing bank"); // [RQ8]

   // status flag follows a read in any bank
   property p_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_READ)
         |=> st_r.zero_flag == ($past(rd_byte) == 8'h00);
   endproperty
   a_flag: assert property (p_flag) else $error("zero flag wrong"); // [RQ9]

   // unmapped apb read answers zero
   property p_unmapped;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_rd && req.paddr[3:0] != 4'h0 && req.paddr[3:0] != 4'h8 && req.paddr[3:0] != 4'hC)
         |=> prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // [RQ3]

   // program counter write through data space
   property p_pc;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_WRITE
         && eff_addr == {bdma_pkg::SFR_BANK, bdma_pkg::PC_LOW_ADDR})
         |=> pc_low_out == $past(req.pwdata[31:24]);
   endproperty
   a_pc: assert property (p_pc) else $error("pc not written"); // [RQ12]

   // pready answers one cycle into the access phase, then drops
   property p_ready;
      @(posedge ref_clk) disable iff (!rst_n)
      (psel && penable && !pready) |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing"); // [RQ1]

   // apb read of bank select carries the four live bits, zero above
   property p_bank_rd;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_rd && req.paddr == bdma_pkg::APB_BANK_SEL)
         |=> prdata == {28'h0, $past(bank_sel_out)};
   endproperty
   a_bank_rd: assert property (p_bank_rd) else $error("bank select readback wrong"); // [RQ6]

   // apb read of the program counter byte
   property p_pc_rd;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_rd && req.paddr == bdma_pkg::APB_PC)
         |=> prdata == {24'h0, $past(pc_low_out)};
   endproperty
   a_pc_rd: assert property (p_pc_rd) else $error("pc readback wrong"); // [RQ12]

   // write to a dead sfr byte touches neither bank select nor pc
   property p_drop_dead;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_WRITE
         && eff_addr[11:8] == bdma_pkg::SFR_BANK && eff_addr[7:0] != bdma_pkg::PC_LOW_ADDR
         && eff_addr[7:0] != bdma_pkg::BANK_SEL_ADDR)
         |=> $stable(pc_low_out) && $stable(bank_sel_out);
   endproperty
   a_drop_dead: assert property (p_drop_dead) else $error("dead write landed"); // [RQ8]

   // read of a dead sfr byte gives zero and sets the zero flag
   property p_dead_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_READ
         && eff_addr[11:8] == bdma_pkg::SFR_BANK && eff_addr[7:0] != bdma_pkg::PC_LOW_ADDR
         && eff_addr[7:0] != bdma_pkg::BANK_SEL_ADDR)
         |=> st_r.result == 8'h00 && st_r.zero_flag;
   endproperty
   a_dead_zero: assert property (p_dead_zero) else $error("dead byte not zero"); // [RQ3]

   // move not aimed at the bank select byte lands at its full address and leaves bank select alone
   property p_move;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_MOVE
         && {req.pwdata[31:28], operand} != {bdma_pkg::SFR_BANK, bdma_pkg::BANK_SEL_ADDR})
         |=> st_r.mv_dst[7:0] == $past(operand)
             && st_r.mv_dst[11:8] == $past(req.pwdata[31:28]) && $stable(bank_sel_out);
   endproperty
   a_move: assert property (p_move) else $error("move target wrong"); // [RQ10]

   // window below the split lands in bank 0
   property p_win_low;
      @(posedge ref_clk) disable iff (!rst_n)
      (access_bit && operand < bdma_pkg::ACCESS_SPLIT) |-> eff_addr == {4'h0, operand};
   endproperty
   a_win_low: assert property (p_win_low) else $error("window low half wrong"); // [RQ4]

   // window from the split up lands in the sfr bank
   property p_win_high;
      @(posedge ref_clk) disable iff (!rst_n)
      (access_bit && operand >= bdma_pkg::ACCESS_SPLIT)
         |-> eff_addr == {bdma_pkg::SFR_BANK, operand};
   endproperty
   a_win_high: assert property (p_win_high) else $error("window high half wrong"); // [RQ4]

   // the operand always supplies the low eight address bits
   property p_low_bits;
      @(posedge ref_clk) disable iff (!rst_n)
      eff_addr[7:0] == operand;
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("low address bits wrong"); // [RQ11]

   // storage write goes to the resolved address with the command's data byte
   property p_store;
      @(posedge ref_clk) disable iff (!rst_n)
      (acc_wr && req.paddr == bdma_pkg::APB_CMD && op == bdma_pkg::BDMA_OP_WRITE
         && eff_addr[11:8] < bdma_pkg::IMPL_BANKS)
         |-> wr_en && wr_addr == eff_addr && wr_data == req.pwdata[31:24];
   endproperty
   a_store: assert property (p_store) else $error("storage write missing"); // [RQ13]

   // pc moves only on an accepted command write
   property p_pc_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      !acc_wr |=> $stable(pc_low_out);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc drifted"); // [RQ12]

   // bank select moves only on an accepted write
   property p_bank_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      !acc_wr |=> $stable(bank_sel_out);
   endproperty
   a_bank_hold: assert property (p_bank_hold) else $error("bank select drifted"); // [RQ7]

   // the status flag moves only with a command
   property p_flag_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      !acc_wr |=> $stable(st_r.zero_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("zero flag drifted"); // [RQ9]
endmodule : bdma_core

// File: bdma_core_model.sv
// core model: issues apb transfers toward the banked addressing block
module bdma_core_model (
   input  wire logic                    ref_clk,
   input  wire logic [31:0]             prdata,
   input  wire logic                    pready,
   output bdma_pkg::bdma_apb_req_s      req
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus from time zero
   initial req = '0;

   // one transfer; entered just after a rising edge, leaves one edge after release
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      q = '0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      // hold the request until pready is seen high at an edge; bounded
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      ok = (pready === 1'b1);
      q = prdata;
      // released bus carries inverted content so stale values cannot pass
      req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
      @(posedge ref_clk);
   endtask : xfer
endmodule : bdma_core_model

// File: bdma_core_tb.sv
// self-checking bench for the banked data memory addressing block
module bdma_core_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [1:0] RD  = bdma_pkg::BDMA_OP_READ;      // banked or window read
   localparam logic [1:0] WR  = bdma_pkg::BDMA_OP_WRITE;     // banked or window write
   localparam logic [1:0] LB  = bdma_pkg::BDMA_OP_LOADBANK;  // load_bank_literal_op
   localparam logic [1:0] MV  = bdma_pkg::BDMA_OP_MOVE;      // full_address_move_op
   localparam logic       WIN = 1'b1;                        // access bit set: window

   logic                    ref_clk;       // core clock
   logic                    rst_n;         // async reset, active low
   bdma_pkg::bdma_apb_req_s req;           // request from the core model
   logic [31:0]             prdata;        // read data
   logic                    pready;        // access answer
   logic                    pslverr;       // error answer, never expected
   logic [3:0]              bank_sel_out;  // bank select seen outside
   logic [7:0]              pc_low_out;    // program counter low byte
   logic [31:0]             q;             // last read word
   int                      mismatches;    // failed comparisons
   int                      cmp_count;     // all comparisons

   // 100 MHz clock
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   bdma_core uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(req.psel), .penable(req.penable),
      .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bank_sel_out(bank_sel_out), .pc_low_out(pc_low_out)
   );
   bdma_core_model core (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .req(req));

   // single comparison point
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic test_done;
      $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // one apb transfer; a hang ends the run
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      core.xfer(wr, a, d, q, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: no answer", $time);
         test_done();
      end
   endtask : bus

   // command word: data, move source, operand, access bit, op
   task automatic cmd(input logic [1:0] op, input logic acc, input logic [7:0] opnd,
                      input logic [7:0] wd, input logic [11:0] src);
      bus(1'b1, bdma_pkg::APB_CMD, {wd, 1'b0, src, opnd, acc, op});
   endtask : cmd

   // read status word after a command
   task automatic stat(input logic [31:0] exp);
      bus(1'b0, bdma_pkg::APB_STATUS, 32'h0);
      chk(q, exp);
   endtask : stat

   initial begin
      rst_n = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // reset values
      bus(1'b0, bdma_pkg::APB_BANK_SEL, 32'h0);
      chk(q, {24'h0, bdma_pkg::BANK_SEL_RST});
      bus(1'b0, bdma_pkg::APB_PC, 32'h0);
      chk(q, {24'h0, bdma_pkg::PC_RST});
      // upper bank bits read zero and ignore writes
      bus(1'b1, bdma_pkg::APB_BANK_SEL, 32'hFFFF_FFFF);
      bus(1'b0, bdma_pkg::APB_BANK_SEL, 32'h0);
      chk(q, 32'h0000_000F);
      // literal load keeps only the low four bits
      cmd(LB, 1'b0, 8'hA5, 8'h00, 12'h000);
      chk({28'h0, bank_sel_out}, 32'h5);
      // a distinct byte at offset 10h of every storage bank
      for (int b = 0; b < 15; b++) begin
         cmd(LB, 1'b0, 8'(b), 8'h00, 12'h000);
         cmd(WR, ~WIN, 8'h10, 8'(b * 16 + 3), 12'h000);
      end
      // read back through bank select; aliasing would show here
      for (int b = 0; b < 15; b++) begin
         cmd(LB, 1'b0, 8'(b), 8'h00, 12'h000);
         cmd(RD, ~WIN, 8'h10, 8'h00, 12'h000);
         stat({24'h0, 8'(b * 16 + 3)});
      end
      // window reaches bank 0 while bank select points elsewhere
      cmd(RD, WIN, 8'h10, 8'h00, 12'h000);
      stat(32'h0000_0003);
      // window upper part reaches the program counter byte
      cmd(WR, WIN, bdma_pkg::PC_LOW_ADDR, 8'h3C, 12'h000);
      chk({24'h0, pc_low_out}, 32'h3C);
      // banked write at F9h with bank 0Fh also hits it
      cmd(LB, 1'b0, 8'h0F, 8'h00, 12'h000);
      cmd(WR, ~WIN, bdma_pkg::PC_LOW_ADDR, 8'h5A, 12'h000);
      bus(1'b0, bdma_pkg::APB_PC, 32'h0);
      chk(q, 32'h0000_005A);
      // unimplemented place: reads zero, drops writes, flag still moves
      cmd(RD, ~WIN, 8'h10, 8'h00, 12'h000);
      stat(32'h0000_0100);
      cmd(WR, ~WIN, 8'h10, 8'h55, 12'h000);
      chk({24'h0, pc_low_out}, 32'h0000_005A);
      stat(32'h0000_0000);
      cmd(RD, ~WIN, 8'h10, 8'h00, 12'h000);
      stat(32'h0000_0100);
      // full address move from bank 3 to bank 2, bank select untouched
      cmd(MV, 1'b0, 8'h44, 8'h20, 12'h310);
      chk({28'h0, bank_sel_out}, 32'hF);
      cmd(LB, 1'b0, 8'h02, 8'h00, 12'h000);
      cmd(RD, ~WIN, 8'h44, 8'h00, 12'h000);
      stat(32'h0000_0033);
      // bank select also sits at E0h of the sfr bank; high bits dropped
      cmd(WR, WIN, bdma_pkg::BANK_SEL_ADDR, 8'hF3, 12'h000);
      chk({28'h0, bank_sel_out}, 32'h3);
      cmd(RD, WIN, bdma_pkg::BANK_SEL_ADDR, 8'h00, 12'h000);
      stat(32'h0000_0003);
      cmd(RD, WIN, bdma_pkg::PC_LOW_ADDR, 8'h00, 12'h000);
      stat(32'h0000_005A);
      // first window byte from the split up is a dead sfr byte
      cmd(RD, WIN, bdma_pkg::ACCESS_SPLIT, 8'h00, 12'h000);
      stat(32'h0000_0100);
      // unmapped and write-only places read zero
      bus(1'b0, 12'h010, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, pslverr}, 32'h0);
      bus(1'b0, bdma_pkg::APB_CMD, 32'h0);
      chk(q, 32'h0);
      test_done();
   end
endmodule : bdma_core_tb
